// ---- inc/ocf_pkg.sv ----
// Purpose: shared constants and types of the oscillator control block
// Assumes: 32-bit AXI4-Lite register port, 40 MHz system clock
// Notes: register indices are word numbers; byte address is four times the index
`default_nettype none
package ocf_pkg;
	// ------------------------------------------------------------
	// register map (word indices)
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [13:0] CTL_IDX = 14'hF86;
	localparam logic [13:0] STS_IDX = 14'hF87;
	localparam logic [13:0] MSK_IDX = 14'hF88;
	localparam logic [13:0] CST_IDX = 14'hF89;

	// ------------------------------------------------------------
	// control register layout and reset value
	// ------------------------------------------------------------
	localparam int CTL_IOSC_EN = 7;
	localparam int CTL_WOSC_EN = 5;
	localparam int CTL_PDET_EN = 4;
	localparam int CTL_WDET_EN = 3;
	localparam logic [7:0] CTL_RST = 8'hA0;
	localparam logic [7:0] UNLOCK_1 = 8'hE7;
	localparam logic [7:0] UNLOCK_2 = 8'h18;

	// clock source select codes
	localparam logic [2:0] SEL_IOSC = 3'h0;
	localparam logic [2:0] SEL_WDT = 3'h3;

	// event status bits
	localparam int EV_PRIM = 0;
	localparam int EV_WDT = 1;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 25;
	localparam int PRIM_FAIL_NS = 1000000;
	localparam int PRIM_FAIL_CYC = PRIM_FAIL_NS / CLK_NS;
	localparam int WDT_FAIL_CYC = 8004;
	localparam int CNT_W = 17;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// unlock tracker states
	typedef enum logic [1:0] {LK_IDLE, LK_GOT1, LK_OPEN} ocf_lk_t;

	// register selected by an address
	typedef enum logic [2:0] {RG_NONE, RG_CTL, RG_STS, RG_MSK, RG_CST} ocf_rg_t;
endpackage
`default_nettype wire

// ---- src/ocf_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module ocf_sync #(
	parameter int WIDTH = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} ocf_sync_st_t;

	ocf_sync_st_t s_r;
	ocf_sync_st_t s_nxt;

	// shift through two stages
	always_comb begin
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;
endmodule
`default_nettype wire

// ---- src/ocf_edge_timer.sv ----
// Purpose: watches a synchronised clock for edges, flags silence
// Assumes: lvl is already synchronised to aclk
// Notes: one pulse per silent spell; re-arms on an edge or on run low
`timescale 1ns/1ps
`default_nettype none
module ocf_edge_timer #(
	parameter int LIMIT = 8004
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic lvl,
	input wire logic run,
	output logic fail
);
	import ocf_pkg::*;

	typedef struct packed {
		logic prev;
		logic [CNT_W-1:0] cnt;
		logic fired;
		logic fail;
	} ocf_et_st_t;

	ocf_et_st_t s_r;
	ocf_et_st_t s_nxt;

	// count cycles since the last edge, pulse once at the limit
	always_comb begin
		s_nxt = s_r;
		s_nxt.prev = lvl;
		s_nxt.fail = 1'b0;
		if (!run || (lvl != s_r.prev)) begin
			s_nxt.cnt = '0;
			s_nxt.fired = 1'b0;
		end else if (!s_r.fired) begin
			if (s_r.cnt == CNT_W'(LIMIT - 1)) begin
				s_nxt.fail = 1'b1;
				s_nxt.fired = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign fail = s_r.fail;

	// failure only after the full silent count
	AST_SILENT_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_r.fail) |-> $past(s_r.cnt) == CNT_W'(LIMIT - 1) && $past(run))
		else $error("silence flagged before the full count");
endmodule
`default_nettype wire

// ---- src/ocf_top.sv ----
// Purpose: oscillator control with unlock, failure detect and recovery
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes: oscillator pins are asynchronous and synchronised before use
//
// Contract
// - control updates need E7H then 18H written first, applying only the next write
// - control writes outside a proper unlock pair change nothing
// - other register traffic between unlock writes does not break the sequence
// - after the update write the register locks again
// - layout: precision osc enable, reserved, watchdog enable, two detects, select
// - reset gives both oscillator enables set, rest zero; no self-disable of precision osc
// - primary failure when system clock falls below about 1 kHz, detection enabled
// - either failure raises a non-maskable event to the CPU
// - primary failure switches to watchdog osc when it is enabled
// - no switch if watchdog osc is selected or disabled
// - watchdog failure alerts only; primary detection ends afterwards
// - watchdog failure after 8004 system cycles without a watchdog edge
// - with the selected source disabled and primary detection off the block stops until reset
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ocf_top #(
	parameter int PRIM_LIMIT = ocf_pkg::PRIM_FAIL_CYC,
	parameter int WDT_LIMIT = ocf_pkg::WDT_FAIL_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ocf_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ocf_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic prim_osc_clk,
	input wire logic wdt_osc_clk,
	output logic [2:0] sys_clk_sel,
	output logic internal_osc_enable,
	output logic wdt_osc_en,
	output logic clk_fail_nmi,
	output logic irq,
	output logic sys_halt
);
	import ocf_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctl;
		ocf_lk_t lk;
		logic [1:0] sts;
		logic [1:0] msk;
		logic wdt_dead;
		logic halted;
		logic nmi;
		logic irq;
		logic aw_h;
		logic [ADDR_W-1:0] awa;
		logic w_h;
		logic [7:0] wd;
		logic wstb;
		logic awrdy;
		logic wrdy;
		logic bvld;
		logic [1:0] bresp;
		logic arrdy;
		logic rvld;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ocf_st_t;

	ocf_st_t s_r;
	ocf_st_t s_nxt;

	logic [1:0] osc_sync;
	logic prim_fail;
	logic wdt_fail;
	logic prim_run;
	logic wdt_run;
	logic wr_go;
	ocf_rg_t wr_rg;
	logic ctl_apply;

	// map a byte address onto a register
	function automatic ocf_rg_t dec(input logic [ADDR_W-1:0] a);
		ocf_rg_t r;
		r = RG_NONE;
		if (a[15:2] == CTL_IDX) r = RG_CTL;
		else if (a[15:2] == STS_IDX) r = RG_STS;
		else if (a[15:2] == MSK_IDX) r = RG_MSK;
		else if (a[15:2] == CST_IDX) r = RG_CST;
		return r;
	endfunction

	// ------------------------------------------------------------
	// oscillator monitors
	// ------------------------------------------------------------

	// pins are free-running oscillators, so two flops before use
	ocf_sync #(.WIDTH(2)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({wdt_osc_clk, prim_osc_clk}),
		.q(osc_sync)
	);

	// primary detect dies for good once the watchdog osc has failed
	assign prim_run = s_r.ctl[CTL_PDET_EN] & ~s_r.wdt_dead & ~s_r.halted;
	// watchdog detect cannot work on its own clock or with it off
	assign wdt_run = s_r.ctl[CTL_WDET_EN] & s_r.ctl[CTL_WOSC_EN]
		& (s_r.ctl[2:0] != SEL_WDT) & ~s_r.wdt_dead;

	// silence window of about one millisecond
	ocf_edge_timer #(.LIMIT(PRIM_LIMIT)) u_prim (
		.aclk(aclk),
		.aresetn(aresetn),
		.lvl(osc_sync[0]),
		.run(prim_run),
		.fail(prim_fail)
	);

	// watchdog osc silence counted in system cycles
	ocf_edge_timer #(.LIMIT(WDT_LIMIT)) u_wdt (
		.aclk(aclk),
		.aresetn(aresetn),
		.lvl(osc_sync[1]),
		.run(wdt_run),
		.fail(wdt_fail)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign wr_go = s_r.aw_h & s_r.w_h & ~s_r.bvld;
	assign wr_rg = dec(s_r.awa);
	assign ctl_apply = wr_go & (wr_rg == RG_CTL) & s_r.wstb & (s_r.lk == LK_OPEN);

	always_comb begin
		s_nxt = s_r;
		s_nxt.nmi = 1'b0;

		// write address and data are taken in either order
		if (s_axi_awvalid && s_r.awrdy) begin
			s_nxt.aw_h = 1'b1;
			s_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wrdy) begin
			s_nxt.w_h = 1'b1;
			s_nxt.wd = s_axi_wdata[7:0];
			s_nxt.wstb = s_axi_wstrb[0];
		end
		if (s_r.bvld && s_axi_bready) begin
			s_nxt.bvld = 1'b0;
		end

		// register write once both halves are here
		if (wr_go) begin
			s_nxt.aw_h = 1'b0;
			s_nxt.w_h = 1'b0;
			s_nxt.bvld = 1'b1;
			s_nxt.bresp = (wr_rg == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (s_r.wstb) begin
				case (wr_rg)
					RG_CTL: begin
						// other registers never touch the tracker
						case (s_r.lk)
							LK_IDLE: begin
								if (s_r.wd == UNLOCK_1) s_nxt.lk = LK_GOT1;
							end
							LK_GOT1: begin
								if (s_r.wd == UNLOCK_2) s_nxt.lk = LK_OPEN;
								else if (s_r.wd != UNLOCK_1) s_nxt.lk = LK_IDLE;
							end
							LK_OPEN: begin
								s_nxt.ctl = s_r.wd;
								s_nxt.lk = LK_IDLE;
							end
							default: begin
								s_nxt.lk = LK_IDLE;
							end
						endcase
					end
					// write one clears; a new event below still wins
					RG_STS: s_nxt.sts = s_r.sts & ~s_r.wd[1:0];
					RG_MSK: s_nxt.msk = s_r.wd[1:0];
					default: begin
					end
				endcase
			end
		end

		// primary failure: alert, and fall back when the watchdog osc can carry us
		if (prim_fail) begin
			s_nxt.sts[EV_PRIM] = 1'b1;
			s_nxt.nmi = 1'b1;
			if (s_r.ctl[CTL_WOSC_EN] && s_r.ctl[2:0] != SEL_WDT) begin
				s_nxt.ctl[2:0] = SEL_WDT;
			end
		end

		// watchdog failure: alert only, select left alone
		if (wdt_fail) begin
			s_nxt.sts[EV_WDT] = 1'b1;
			s_nxt.nmi = 1'b1;
			s_nxt.wdt_dead = 1'b1;
		end

		// selected source disabled and primary detection off: only reset recovers
		if (!s_nxt.ctl[CTL_PDET_EN]
			&& ((s_nxt.ctl[2:0] == SEL_IOSC && !s_nxt.ctl[CTL_IOSC_EN])
			|| (s_nxt.ctl[2:0] == SEL_WDT && !s_nxt.ctl[CTL_WOSC_EN]))) begin
			s_nxt.halted = 1'b1;
		end

		// read channel, answered one cycle after the address
		if (s_r.rvld && s_axi_rready) begin
			s_nxt.rvld = 1'b0;
		end
		if (s_axi_arvalid && s_r.arrdy) begin
			s_nxt.rvld = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			case (dec(s_axi_araddr))
				RG_CTL: s_nxt.rdata = {24'h000000, s_r.ctl};
				RG_STS: s_nxt.rdata = {30'h00000000, s_r.sts};
				RG_MSK: s_nxt.rdata = {30'h00000000, s_r.msk};
				RG_CST: s_nxt.rdata = {24'h000000, s_r.halted, s_r.wdt_dead,
					s_r.lk, 1'b0, s_r.ctl[2:0]};
				default: begin
					s_nxt.rdata = 32'h00000000;
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end

		// ready flags registered so every output comes from a flop
		s_nxt.awrdy = ~s_nxt.aw_h & ~s_nxt.bvld;
		s_nxt.wrdy = ~s_nxt.w_h & ~s_nxt.bvld;
		s_nxt.arrdy = ~s_nxt.rvld;
		s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------

	// reset relocks and restores default enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.ctl <= CTL_RST;
			s_r.lk <= LK_IDLE;
			s_r.awrdy <= 1'b1;
			s_r.wrdy <= 1'b1;
			s_r.arrdy <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = s_r.awrdy;
	assign s_axi_wready = s_r.wrdy;
	assign s_axi_bvalid = s_r.bvld;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arrdy;
	assign s_axi_rvalid = s_r.rvld;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign sys_clk_sel = s_r.ctl[2:0];
	assign internal_osc_enable = s_r.ctl[CTL_IOSC_EN];
	assign wdt_osc_en = s_r.ctl[CTL_WOSC_EN];
	assign clk_fail_nmi = s_r.nmi;
	assign irq = s_r.irq;
	assign sys_halt = s_r.halted;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_CTL_ONLY_OPEN: assert property (
		$past(aresetn) && $changed(s_r.ctl) && !$past(prim_fail) |-> $past(s_r.lk) == LK_OPEN)
		else $error("control changed without unlock");

	AST_LOCKED_HOLD: assert property (
		wr_go && wr_rg == RG_CTL && s_r.lk != LK_OPEN && !prim_fail |=> $stable(s_r.ctl))
		else $error("locked control register changed");

	AST_OTHER_KEEP: assert property (
		wr_go && wr_rg != RG_CTL |=> $stable(s_r.lk))
		else $error("other register write disturbed unlock");

	AST_RELOCK: assert property (
		ctl_apply |=> s_r.lk == LK_IDLE && s_r.ctl[7:3] == $past(s_r.wd[7:3]))
		else $error("no relock after update");

	AST_RESET_VAL: assert property (
		$rose(aresetn) |-> s_r.ctl == CTL_RST && s_r.lk == LK_IDLE)
		else $error("bad state after reset");

	AST_NMI: assert property (
		prim_fail || wdt_fail |=> clk_fail_nmi)
		else $error("failure without event");

	// the event is a pulse: high only right after a failure
	AST_NMI_CAUSE: assert property (
		clk_fail_nmi |-> $past(prim_fail) || $past(wdt_fail))
		else $error("event without failure");

	AST_SWITCH: assert property (
		prim_fail && s_r.ctl[CTL_WOSC_EN] |=> sys_clk_sel == SEL_WDT)
		else $error("no switch to watchdog osc");

	AST_NO_SWITCH: assert property (
		prim_fail && !s_r.ctl[CTL_WOSC_EN] && !ctl_apply |=> $stable(sys_clk_sel))
		else $error("switch with watchdog osc off");

	AST_WDT_ONLY_ALERT: assert property (
		wdt_fail && !prim_fail && !ctl_apply |=> $stable(sys_clk_sel) ##1 !prim_run)
		else $error("watchdog failure changed select");

	AST_HALT_STICKY: assert property (
		sys_halt |=> sys_halt)
		else $error("halt released without reset");

	COV_UNLOCK_WRITE: cover property (ctl_apply);
	COV_PRIM_SWITCH: cover property (prim_fail && s_r.ctl[CTL_WOSC_EN]);
	COV_WDT_FAIL: cover property (wdt_fail);
	COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the oscillator control block
// Assumes: short failure limits; oscillator pins driven as square waves with periods of 2 and 8 system cycles
// Notes: bus tasks sample readies right after the edge, i.e. the value at that edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ocf_pkg::*;
	localparam int PL = 20;
	localparam int WL = 16;
	localparam logic [15:0] CA = {CTL_IDX, 2'b00};
	localparam logic [15:0] SA = {STS_IDX, 2'b00};
	localparam logic [15:0] MA = {MSK_IDX, 2'b00};
	localparam logic [15:0] XA = {CST_IDX, 2'b00};
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wr, bv, arr, rv, nmi, irq, halt, iosc, wen, pck = 0, wck = 0;
	logic prun = 1, wrun = 1;
	logic [15:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic [3:0] ws = 0;
	logic [1:0] br, rr, rsp;
	logic [2:0] sel;
	logic [31:0] v;
	int bad_count = 0, checks_done = 0, n;
	ocf_top #(.PRIM_LIMIT(PL), .WDT_LIMIT(WL)) ocf_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .prim_osc_clk(pck), .wdt_osc_clk(wck), .sys_clk_sel(sel),
		.internal_osc_enable(iosc), .wdt_osc_en(wen), .clk_fail_nmi(nmi), .irq(irq),
		.sys_halt(halt));
	// ------------------------------------------------------------
	// clock, oscillator pins, watchdog
	// ------------------------------------------------------------
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	// pins stand still when stopped, which is how a dead oscillator looks
	always @(posedge aclk) begin
		if (prun) pck <= ~pck;
		if (wrun && $time % 100 < 25) wck <= ~wck;
	end
	initial begin
		#(25 * 20000);
		bad_count++;
		print_verdict();
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask
	task automatic rst();
		aresetn <= 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
	endtask
	// both halves offered together, each dropped once taken
	// bready and rready stay up between transfers, so no same-step toggle
	task automatic bw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		logic pa, pw;
		int k;
		pa = 1;
		pw = 1;
		k = 0;
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		while (k < 50) begin
			@(posedge aclk);
			k++;
			if (!pa && !pw && bv) break;
			if (pa && awr) begin
				pa = 0;
				awv <= 0;
			end
			if (pw && wr) begin
				pw = 0;
				wv <= 0;
			end
		end
		if (k == 50) bad_count++;
		rsp = br;
	endtask
	task automatic br_(input logic [15:0] a);
		logic pa;
		int k;
		pa = 1;
		k = 0;
		ara <= a;
		arv <= 1;
		rry <= 1;
		while (k < 50) begin
			@(posedge aclk);
			k++;
			if (!pa && rv) break;
			if (pa && arr) begin
				pa = 0;
				arv <= 0;
			end
		end
		if (k == 50) bad_count++;
		v = rd;
		rsp = rr;
	endtask
	task automatic unl(input logic [7:0] x);
		bw(CA, 32'h000000E7);
		bw(CA, 32'h00000018);
		bw(CA, {24'h0, x});
	endtask
	task automatic wnmi(input int lim);
		n = 0;
		while (n < lim) begin
			@(posedge aclk);
			n++;
			if (nmi === 1'b1) break;
		end
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_lock();
		br_(CA);
		chk(v, 32'h000000A0);
		chk({iosc, wen, sel}, {1'b1, 1'b1, 3'h0});
		bw(CA, 32'h00000023);
		bw(CA, 32'h00000018);
		bw(CA, 32'h000000E7);
		bw(CA, 32'h00000023);
		br_(CA);
		chk(v, 32'h000000A0);
		// unlock pair split by traffic to other registers
		bw(CA, 32'h000000E7);
		br_(SA);
		br_(XA);
		chk(v, 32'h00000010);
		bw(CA, 32'h00000018);
		bw(MA, 32'h00000000);
		// a write with its low strobe off must leave the tracker open
		bw(CA, 32'h00000021, 4'h0);
		bw(CA, 32'h000000E2);
		br_(CA);
		chk(v, 32'h000000E2);
		chk({iosc, wen, sel}, {1'b1, 1'b1, 3'h2});
		bw(CA, 32'h00000021);
		br_(CA);
		chk(v, 32'h000000E2);
		bw(16'h3FFC, 32'h00000001);
		chk(rsp, RESP_SLVERR);
		br_(16'h3FFC);
		chk(rsp, RESP_SLVERR);
		// open unlock with no update written must not survive a reset
		bw(CA, 32'h000000E7);
		bw(CA, 32'h00000018);
		rst();
		bw(CA, 32'h00000021);
		br_(CA);
		chk(v, 32'h000000A0);
	endtask
	task automatic t_prim(input logic [7:0] c, input logic [2:0] es, input logic m);
		rst();
		bw(MA, {31'h0, m});
		unl(c);
		repeat (10) @(posedge aclk);
		prun <= 0;
		wnmi(4 * PL);
		chk(n >= PL / 2 && n <= 2 * PL, 1);
		prun <= 1;
		repeat (3) @(posedge aclk);
		chk(sel, es);
		chk(iosc, 1);
		chk(irq, m);
		br_(SA);
		chk(v, 32'h00000001);
		bw(SA, 32'h00000001);
		br_(SA);
		chk(v, 32'h00000000);
		chk(irq, 0);
	endtask
	task automatic t_wdt();
		rst();
		unl(8'hA8);
		repeat (10) @(posedge aclk);
		wrun <= 0;
		wnmi(4 * WL);
		chk(n >= WL && n <= WL + 8, 1);
		wrun <= 1;
		chk(sel, 3'h0);
		br_(SA);
		chk(v, 32'h00000002);
		br_(XA);
		chk(v, 32'h00000040);
		unl(8'hB0);
		prun <= 0;
		wnmi(4 * PL);
		chk(n, 4 * PL);
		prun <= 1;
	endtask
	task automatic t_halt();
		rst();
		unl(8'h20);
		repeat (3) @(posedge aclk);
		chk(halt, 1);
		br_(XA);
		chk(v, 32'h00000080);
		rst();
		chk(halt, 0);
		br_(CA);
		chk(v, 32'h000000A0);
	endtask
	initial begin
		rst();
		t_lock();
		t_prim(8'hB0, SEL_WDT, 1);
		t_prim(8'h90, SEL_IOSC, 0);
		t_wdt();
		t_halt();
		print_verdict();
	end
endmodule
`default_nettype wire
